/* wide_target_cfg.svh */
// Operation
// RULE_01: Wide single read 5 clocks, write 3
// RULE_02: Burst read 4-1-1-1 plus turnaround; write 3-1-1-1 (code: burst ready low at most every other clock)
// RULE_03: ID 0, 1, 4 high means wide-capable
// RULE_04: ID pair decodes protocol and size awareness
// RULE_05: Upper data rides address and select lines
// RULE_06: Upper enables gate upper lanes, shared pins
// RULE_07: Initiator transfers contiguous bytes only
// RULE_08: Offer strobed with address strobe, one clock
// RULE_09: Master never offers wide to unaware board
// RULE_10: Addressed target acknowledges in first/second data state
// RULE_11: Acknowledge low one state, high one, float
// RULE_12: No ready low before or with acknowledge
// RULE_13: No acknowledge without a wide offer
// RULE_14: Acknowledge shares ID4 pin after reset
// RULE_15: Write upper data follows acknowledge clock
// RULE_16: Read: no upper data on acknowledge clock
// RULE_17: Master holds burst-last until acknowledge
// RULE_18: Late acknowledge delays line switching
// RULE_19: Hold read data until ready-return sampled
// RULE_20: Burst enables active; lower implied after first
// RULE_21: New burst write data per burst ready
// RULE_22: Burst read turnaround before and after data
// RULE_23: Ready before acknowledge means 32-bit transfer
// RULE_24: Wide only memory, A2 zero, straddling word
// RULE_25: Wide target still works as 32-bit target
`ifndef WIDE_TARGET_CFG_SVH
`define WIDE_TARGET_CFG_SVH
`define WT_ID_WIDE 3'h7
`define WT_LAST_BEAT 2'h3
`define WT_REQ_W 104
`define WT_REQ_DATA 0
`define WT_REQ_LANES 64
`define WT_REQ_WIDE 72
`define WT_REQ_WRITE 73
`define WT_REQ_ADDR 74
`define WT_RST_DATA 64'h0
`endif

/* wt_pkg.sv */
package wt_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DEC = 6'h02,
		ST_ACK = 6'h04,
		ST_BEAT = 6'h08,
		ST_RTN = 6'h10,
		ST_TURN = 6'h20
	} wt_state_t;
	typedef enum logic [1:0] {
		PR_RESERVED = 2'h0,
		PR_OLDER = 2'h1,
		PR_NEWER = 2'h2,
		PR_WIDE = 2'h3
	} wt_proto_t;
endpackage

/* wt_buffer.sv */
`timescale 1ns/1ns
module wt_buffer
#(
	parameter int W = 8
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	logic skid_valid_r;
	logic [W-1:0] skid_r;
	logic push;
	logic pop;

	if (W < 1)
	begin : g_chk
		$error("wt_buffer width must be positive");
	end

	// Both outputs are flops; the skid entry absorbs one stalled word
	assign in_ready = !skid_valid_r;
	assign push = in_valid && !skid_valid_r;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			out_valid <= 1'b0;
			skid_valid_r <= 1'b0;
			out_data <= '0;
			skid_r <= '0;
		end
		else if (pop)
		begin
			if (skid_valid_r)
			begin
				out_data <= skid_r;
				skid_valid_r <= 1'b0;
			end
			else if (push)
				out_data <= in_data;
			else
				out_valid <= 1'b0;
		end
		else if (push)
		begin
			if (!out_valid)
			begin
				out_data <= in_data;
				out_valid <= 1'b1;
			end
			else
			begin
				skid_r <= in_data;
				skid_valid_r <= 1'b1;
			end
		end
	end
endmodule

/* wt_caps.sv */
`timescale 1ns/1ns
`include "wide_target_cfg.svh"
module wt_caps
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] id_bits,
	output logic wide_aware,
	output wt_pkg::wt_proto_t proto
);
	logic first_r;

	function automatic wt_pkg::wt_proto_t decode(input logic [2:0] id);
		case (id[1:0])
			2'h1: decode = wt_pkg::PR_OLDER;
			2'h2: decode = wt_pkg::PR_NEWER;
			2'h3: decode = id[2] ? wt_pkg::PR_WIDE : wt_pkg::PR_NEWER;
			default: decode = wt_pkg::PR_RESERVED;
		endcase
	endfunction

	// Pins are caught on the first edge after release, never by the reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			first_r <= 1'b1;
			wide_aware <= 1'b0;
			proto <= wt_pkg::PR_RESERVED;
		end
		else if (first_r)
		begin
			first_r <= 1'b0;
			wide_aware <= (id_bits == `WT_ID_WIDE); // see RULE_03
			proto <= decode(id_bits); // see RULE_04
		end
	end

	property p_caps;
		@(posedge clk) disable iff (reset)
		first_r |=> !first_r && (wide_aware == (&$past(id_bits)));
	endproperty
	a_caps: assert property (p_caps) // see RULE_03
		else $error("capability not taken from id pins");
endmodule

/* wide_target.sv */
`timescale 1ns/1ns
`include "wide_target_cfg.svh"
module wide_target
#(
	parameter logic [29:0] DEC_BASE = 30'h0,
	parameter logic [29:0] DEC_MASK = 30'h0,
	parameter bit ACK_LATE = 1'b0,
	parameter bit WIDE_EN = 1'b1,
	parameter bit BURST_EN = 1'b1
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic addr_strobe_n,
	input wire logic wide_offer_n,
	input wire logic burst_last_n,
	input wire logic ready_return_n,
	input wire logic [29:0] bus_addr,
	input wire logic bus_mem_io,
	input wire logic bus_write_read,
	input wire logic [3:0] lane_enables_n,
	input wire logic [31:0] bus_data,
	input wire logic [1:0] board_id_bits,
	input wire logic ack_pin,
	output logic wide_ack_n,
	output logic wide_ack_oe,
	output logic device_claim_n,
	output logic local_ready_n,
	output logic local_ready_oe,
	output logic burst_ready_n,
	output logic burst_ready_oe,
	output logic [31:0] lower_data_word,
	output logic lower_data_oe,
	output logic [31:0] upper_data_word,
	output logic upper_data_oe,
	output logic req_valid,
	input wire logic req_ready,
	output logic [29:0] req_addr,
	output logic req_write,
	output logic req_wide,
	output logic [7:0] req_lanes,
	output logic [63:0] req_data,
	input wire logic rsp_valid,
	input wire logic [63:0] rsp_data,
	output logic rsp_ready,
	output logic caps_wide,
	output wt_pkg::wt_proto_t caps_proto
);
	localparam int ACK_DLY = ACK_LATE ? 2 : 1;

	wt_pkg::wt_state_t state_r;
	wt_pkg::wt_state_t state_nxt;
	logic [29:0] addr_r;
	logic [3:0] be_lo_r;
	logic [1:0] beat_r;
	logic write_r;
	logic wide_r;
	logic use_b_r;
	logic rdy_low_r;
	logic sent_r;
	logic hit;
	logic start;
	logic go_wide;
	logic use_b_nxt;
	logic beat_done;
	logic last;
	logic take;
	logic push_now;
	logic rdy_set;
	logic drive_rdy;
	logic buf_in_ready;
	logic [7:0] push_lanes;
	logic [63:0] push_data;
	logic [29:0] beat_addr;
	logic [`WT_REQ_W-1:0] push_word;
	logic [`WT_REQ_W-1:0] pop_word;

	if ((DEC_BASE & ~DEC_MASK) != 30'h0)
	begin : g_chk
		$error("decode base has bits outside the mask");
	end

	wt_caps u_caps
	(
		.clk(clk),
		.reset(reset),
		.id_bits({ack_pin, board_id_bits}),
		.wide_aware(caps_wide),
		.proto(caps_proto)
	);

	assign hit = (bus_addr & DEC_MASK) == DEC_BASE;
	assign start = (state_r == wt_pkg::ST_IDLE) && !addr_strobe_n && hit;
	// Offer counts only with the strobe, from a wide-aware board
	assign go_wide = WIDE_EN && caps_wide && !wide_offer_n // see RULE_09
		&& !bus_addr[0] && bus_mem_io; // see RULE_24
	assign use_b_nxt = start ? (go_wide && BURST_EN) : use_b_r;
	assign beat_done = (state_r == wt_pkg::ST_BEAT) && rdy_low_r;
	assign last = !use_b_r || !burst_last_n || (beat_r == `WT_LAST_BEAT);
	assign take = rsp_valid && rsp_ready;
	assign push_now = (state_r == wt_pkg::ST_BEAT)
		&& (write_r ? beat_done : (!sent_r && buf_in_ready));
	// Buffer room or returned data gates each beat, inserting wait states
	assign rdy_set = (state_r == wt_pkg::ST_ACK && write_r && buf_in_ready)
		|| (state_r == wt_pkg::ST_BEAT && !rdy_low_r
		&& (write_r ? buf_in_ready : take)); // see RULE_21
	assign drive_rdy = (state_nxt == wt_pkg::ST_BEAT)
		|| (state_nxt == wt_pkg::ST_RTN) || (state_nxt == wt_pkg::ST_TURN);

	// Burst beats walk the line in the order the start address implies
	assign beat_addr = {addr_r[29:3], addr_r[2:1] ^ beat_r, addr_r[0]};
	assign push_lanes = wide_r
		? {~lane_enables_n, (beat_r == 2'h0) ? ~be_lo_r : 4'hF} // see RULE_20
		: {4'h0, ~be_lo_r}; // see RULE_06
	// Upper write word sits on address and select lines after the ack
	assign push_data = !write_r ? `WT_RST_DATA
		: wide_r ? {bus_addr, bus_mem_io, bus_write_read, bus_data} // see RULE_05
		: {32'h0, bus_data}; // see RULE_15
	assign push_word = {beat_addr, write_r, wide_r, push_lanes, push_data};

	wt_buffer #(.W(`WT_REQ_W)) u_buf
	(
		.clk(clk),
		.reset(reset),
		.in_valid(push_now),
		.in_data(push_word),
		.in_ready(buf_in_ready),
		.out_valid(req_valid),
		.out_data(pop_word),
		.out_ready(req_ready)
	);

	assign req_addr = pop_word[`WT_REQ_ADDR +: 30];
	assign req_write = pop_word[`WT_REQ_WRITE];
	assign req_wide = pop_word[`WT_REQ_WIDE];
	assign req_lanes = pop_word[`WT_REQ_LANES +: 8];
	assign req_data = pop_word[`WT_REQ_DATA +: 64];

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			wt_pkg::ST_IDLE:
				if (start)
					state_nxt = !go_wide ? wt_pkg::ST_BEAT // see RULE_25
						: ACK_LATE ? wt_pkg::ST_DEC : wt_pkg::ST_ACK;
			wt_pkg::ST_DEC: state_nxt = wt_pkg::ST_ACK;
			wt_pkg::ST_ACK: state_nxt = wt_pkg::ST_BEAT;
			wt_pkg::ST_BEAT:
				if (beat_done && last)
					state_nxt = (!write_r && !use_b_r && ready_return_n)
						? wt_pkg::ST_RTN : wt_pkg::ST_TURN;
			wt_pkg::ST_RTN:
				if (!ready_return_n)
					state_nxt = wt_pkg::ST_TURN; // see RULE_19
			wt_pkg::ST_TURN: state_nxt = wt_pkg::ST_IDLE;
			default: state_nxt = wt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state_r <= wt_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			addr_r <= 30'h0;
			write_r <= 1'b0;
			wide_r <= 1'b0;
			use_b_r <= 1'b0;
			be_lo_r <= 4'hF;
			beat_r <= 2'h0;
		end
		else if (start)
		begin
			addr_r <= bus_addr;
			write_r <= bus_write_read;
			wide_r <= go_wide;
			use_b_r <= use_b_nxt;
			be_lo_r <= lane_enables_n;
			beat_r <= 2'h0;
		end
		else if (beat_done)
			beat_r <= beat_r + 2'h1;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			sent_r <= 1'b0;
		else if (start || beat_done)
			sent_r <= 1'b0;
		else if (push_now)
			sent_r <= 1'b1;
	end

	// Claim holds from decode until the bus is handed back
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			device_claim_n <= 1'b1;
		else
			device_claim_n <= (state_nxt == wt_pkg::ST_IDLE); // see RULE_10
	end

	// Pin is released through reset so the board can show its ID4 strap
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wide_ack_n <= 1'b1;
			wide_ack_oe <= 1'b0; // see RULE_14
		end
		else
		begin
			wide_ack_n <= (state_nxt != wt_pkg::ST_ACK); // see RULE_13
			wide_ack_oe <= (state_nxt == wt_pkg::ST_ACK)
				|| (state_r == wt_pkg::ST_ACK); // see RULE_11
		end
	end

	// Ready first leaves in the state after the ack, then is driven high
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rdy_low_r <= 1'b0;
			local_ready_n <= 1'b1;
			burst_ready_n <= 1'b1;
			local_ready_oe <= 1'b0;
			burst_ready_oe <= 1'b0;
		end
		else
		begin
			rdy_low_r <= rdy_set;
			local_ready_n <= !(rdy_set && !use_b_r); // see RULE_12
			burst_ready_n <= !(rdy_set && use_b_r); // see RULE_02
			local_ready_oe <= drive_rdy && !use_b_nxt;
			burst_ready_oe <= drive_rdy && use_b_nxt;
		end
	end

	// Data is driven only from the reply, never in the ack-high clock
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lower_data_word <= 32'h0;
			upper_data_word <= 32'h0;
			lower_data_oe <= 1'b0;
			upper_data_oe <= 1'b0;
		end
		else if (take)
		begin
			lower_data_word <= rsp_data[31:0];
			upper_data_word <= rsp_data[63:32]; // see RULE_05
			lower_data_oe <= 1'b1;
			upper_data_oe <= wide_r; // see RULE_16
		end
		else if (state_nxt == wt_pkg::ST_TURN || state_nxt == wt_pkg::ST_IDLE)
		begin
			lower_data_oe <= 1'b0; // see RULE_22
			upper_data_oe <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rsp_ready <= 1'b0;
		else
			rsp_ready <= (state_r == wt_pkg::ST_BEAT) && !write_r
				&& (sent_r || push_now) && !take && !rdy_low_r;
	end

	property p_ack_offer;
		@(posedge clk) disable iff (reset)
		$rose(wide_ack_oe) |->
			!$past(addr_strobe_n, ACK_DLY) && !$past(wide_offer_n, ACK_DLY)
			&& !device_claim_n;
	endproperty
	a_ack_offer: assert property (p_ack_offer) // see RULE_13
		else $error("acknowledge without an offer");

	property p_ack_shape;
		@(posedge clk) disable iff (reset)
		(wide_ack_oe && !wide_ack_n) |=>
			(wide_ack_oe && wide_ack_n) ##1 !wide_ack_oe;
	endproperty
	a_ack_shape: assert property (p_ack_shape) // see RULE_11
		else $error("acknowledge not low, high, then released");

	property p_rdy_ack;
		@(posedge clk) disable iff (reset)
		(wide_ack_oe && !wide_ack_n) |-> (local_ready_n && burst_ready_n);
	endproperty
	a_rdy_ack: assert property (p_rdy_ack) // see RULE_12
		else $error("ready low together with acknowledge");

	property p_wr_min;
		@(posedge clk) disable iff (reset)
		(start && go_wide && bus_write_read) |=>
			(local_ready_n && burst_ready_n);
	endproperty
	a_wr_min: assert property (p_wr_min) // see RULE_01
		else $error("wide write faster than three clocks");

	property p_rd_min;
		@(posedge clk) disable iff (reset)
		(start && go_wide && !bus_write_read) |=>
			(local_ready_n && burst_ready_n && !lower_data_oe)[*2];
	endproperty
	a_rd_min: assert property (p_rd_min) // see RULE_02
		else $error("wide read first data too early");

	property p_no_hi_ack;
		@(posedge clk) disable iff (reset)
		(wide_ack_oe && wide_ack_n) |-> !upper_data_oe;
	endproperty
	a_no_hi_ack: assert property (p_no_hi_ack) // see RULE_16
		else $error("upper data driven in acknowledge clock");

	property p_rtn_hold;
		@(posedge clk) disable iff (reset)
		(state_r == wt_pkg::ST_RTN) |-> lower_data_oe;
	endproperty
	a_rtn_hold: assert property (p_rtn_hold) // see RULE_19
		else $error("read data dropped before ready return");

	property p_turn;
		@(posedge clk) disable iff (reset)
		(beat_done && last && use_b_r && !write_r) |=>
			!lower_data_oe && !upper_data_oe && burst_ready_n;
	endproperty
	a_turn: assert property (p_turn) // see RULE_22
		else $error("no turnaround after burst read");
endmodule

/* wt_bus_model.sv */
`timescale 1ns/1ns
module wt_bus_model
(
	input wire logic clk,
	input wire logic reset,
	output logic addr_strobe_n,
	output logic wide_offer_n,
	output logic burst_last_n,
	output logic ready_return_n,
	output logic [29:0] bus_addr,
	output logic bus_mem_io,
	output logic bus_write_read,
	output logic [3:0] lane_enables_n,
	output logic [31:0] bus_data,
	output logic [1:0] board_id_bits,
	output logic ack_pin,
	input wire logic wide_ack_n,
	input wire logic wide_ack_oe,
	input wire logic local_ready_n,
	input wire logic local_ready_oe,
	input wire logic burst_ready_n,
	input wire logic burst_ready_oe,
	input wire logic [31:0] lower_data_word,
	input wire logic [31:0] upper_data_word,
	input wire logic upper_data_oe,
	input wire logic lower_data_oe
);
	logic id4 = 1'b1;
	logic [1:0] id_cnt;
	logic lr_q = 1'b0;
	int ack_cyc;
	int rdy_cyc;
	int got;
	bit bad;
	bit held;
	bit rr_lag;
	logic [63:0] rd [4];
	wire logic ack = wide_ack_oe && !wide_ack_n;
	wire logic lr = local_ready_oe && !local_ready_n;
	wire logic rdy = lr || (burst_ready_oe && !burst_ready_n);

	// Board drives ID4 only around reset; pull-up holds it high later
	assign ack_pin = wide_ack_oe ? wide_ack_n
		: (id_cnt != 2'h2 ? id4 : 1'b1);

	initial
	begin
		addr_strobe_n = 1'b1;
		wide_offer_n = 1'b1;
		burst_last_n = 1'b1;
		ready_return_n = 1'b1;
		bus_addr = 30'h0;
		bus_mem_io = 1'b1;
		bus_write_read = 1'b0;
		lane_enables_n = 4'hF;
		bus_data = 32'h0;
		board_id_bits = 2'h3;
	end

	always @(posedge clk or posedge reset)
		if (reset)
			id_cnt <= 2'h0;
		else if (id_cnt != 2'h2)
			id_cnt <= id_cnt + 2'h1;

	always @(negedge clk)
	begin
		lr_q <= lr;
		ready_return_n <= rr_lag ? !lr_q : !lr;
		if (wide_ack_oe && id_cnt != 2'h2)
			bad = 1'b1;
	end

	task automatic run(input bit wr, input bit offer, input int beats,
		input logic [29:0] a, input logic [3:0] lo_n,
		input logic [3:0] hi_n, input logic [63:0] d);
		int cyc;
		bit step;
		cyc = 0;
		step = 1'b0;
		ack_cyc = 0;
		rdy_cyc = 0;
		got = 0;
		bad = 1'b0;
		@(negedge clk);
		addr_strobe_n = 1'b0;
		wide_offer_n = !offer;
		burst_last_n = offer;
		bus_addr = a;
		bus_mem_io = 1'b1;
		bus_write_read = wr;
		lane_enables_n = lo_n;
		bus_data = d[31:0];
		while (got < beats && cyc < 40)
		begin
			@(negedge clk);
			cyc++;
			addr_strobe_n = 1'b1;
			wide_offer_n = 1'b1;
			// Lines change only after the edge that sampled ack or ready
			if (step)
			begin
				if (got > 0)
					d = d + 64'h0101_0101_0101_0101;
				{bus_addr, bus_mem_io, bus_write_read} = wr ? d[63:32]
					: ~{bus_addr, bus_mem_io, bus_write_read};
				bus_data = wr ? d[31:0] : ~bus_data;
				lane_enables_n = hi_n;
				burst_last_n = got != beats - 1;
			end
			step = 1'b0;
			if (ack && ack_cyc == 0 && got == 0)
			begin
				ack_cyc = cyc;
				step = 1'b1;
			end
			if (ack_cyc != 0 && cyc == ack_cyc + 1)
				bad |= !wide_ack_oe || !wide_ack_n || upper_data_oe;
			if (ack_cyc != 0 && cyc == ack_cyc + 2)
				bad |= wide_ack_oe;
			if (rdy)
			begin
				bad |= ack;
				if (got == 0)
					rdy_cyc = cyc;
				rd[got] = {upper_data_word, lower_data_word};
				got++;
				step = 1'b1;
			end
		end
		@(negedge clk);
		held = lower_data_oe;
		bus_addr = ~bus_addr;
		bus_data = ~bus_data;
		lane_enables_n = 4'hF;
		burst_last_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
endmodule

/* wide_target_tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("CHECK FAILED at %0t: got %0h expected %0h", \
				$time, (g), (e)); \
		end \
	end
module wide_target_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic addr_strobe_n, wide_offer_n, burst_last_n, ready_return_n;
	logic [29:0] bus_addr, req_addr;
	logic bus_mem_io, bus_write_read, ack_pin, wide_ack_n, wide_ack_oe;
	logic [3:0] lane_enables_n;
	logic [31:0] bus_data, lower_data_word, upper_data_word;
	logic [1:0] board_id_bits;
	logic local_ready_n, local_ready_oe, burst_ready_n, burst_ready_oe;
	logic lower_data_oe, upper_data_oe, req_valid, req_write, req_wide;
	logic rsp_ready, caps_wide, device_claim_n;
	logic [7:0] req_lanes;
	logic [63:0] req_data;
	logic req_ready = 1'b0;
	logic rsp_valid = 1'b0;
	logic [63:0] rsp_data = 64'h0;
	wt_pkg::wt_proto_t caps_proto;
	int fail_count, check_count, cycles, pend, num;
	bit rq_en = 1'b1;
	bit take;
	logic [103:0] q [$];
	localparam logic [63:0] D = 64'hFEDC_BA98_7654_3210;

	wide_target uut (.*);
	wt_bus_model m (.*);

	initial
		forever #25 clk = ~clk;

	function automatic logic [63:0] pat(input int k);
		return 64'h0123_4567_89AB_CDEF ^ {8{k[7:0]}};
	endfunction

	// Settle handshakes on the falling edge, one write per signal except pend, which can step down and up
	always @(negedge clk)
	begin
		if (take)
		begin
			pend--;
			num++;
		end
		req_ready = rq_en;
		if (req_valid && req_ready)
		begin
			q.push_back({req_wide, req_write, req_lanes, req_addr, req_data});
			if (!req_write)
				pend++;
		end
		rsp_valid = pend != 0;
		rsp_data = pat(num);
		take = rsp_valid && rsp_ready;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			stop_test;
		end
	end

	task automatic do_reset(input logic [1:0] pair, input logic i4);
		@(negedge clk);
		reset = 1'b1;
		m.board_id_bits = pair;
		m.id4 = i4;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic t_caps;
		logic [103:0] r;
		for (int i = 0; i < 5; i++)
		begin
			do_reset(i == 4 ? 2'h3 : 2'(i), i != 3);
			`CHK(caps_wide, i == 4)
			`CHK(caps_proto, i == 4 ? 2'h3 : i == 3 ? 2'h2 : 2'(i))
			if (i == 3)
			begin
				m.run(1'b1, 1'b1, 1, 30'h2400, 4'h3, 4'hE, D);
				r = q.pop_front();
				`CHK(m.ack_cyc, 0)
				`CHK(r[103:102], 2'h1)
			end
		end
	endtask

	task automatic t_wide_wr;
		logic [103:0] r;
		m.run(1'b1, 1'b1, 1, 30'h2400, 4'h3, 4'hE, D);
		`CHK(m.ack_cyc, 1)
		`CHK(m.bad, 1'b0)
		`CHK(m.rdy_cyc >= 2, 1'b1)
		r = q.pop_front();
		`CHK(r, {2'h3, 8'h1C, 30'h2400, D})
	endtask

	task automatic t_wide_rd;
		int b;
		logic [103:0] r;
		b = num;
		m.run(1'b0, 1'b1, 1, 30'h2400, 4'h0, 4'h0, D);
		`CHK(m.ack_cyc, 1)
		`CHK(m.bad, 1'b0)
		`CHK(m.rdy_cyc >= 3, 1'b1)
		`CHK(m.rd[0], pat(b))
		r = q.pop_front();
		`CHK(r, {2'h2, 8'hFF, 30'h2400, 64'h0})
	endtask

	task automatic t_narrow;
		logic [103:0] r;
		logic [63:0] e;
		e = pat(num);
		m.run(1'b1, 1'b0, 1, 30'h2401, 4'h0, 4'h0, D);
		r = q.pop_front();
		`CHK(m.ack_cyc, 0)
		`CHK({r[103:102], r[31:0]}, {2'h1, D[31:0]})
		m.rr_lag = 1'b1;
		m.run(1'b0, 1'b0, 1, 30'h2401, 4'h0, 4'h0, D);
		m.rr_lag = 1'b0;
		`CHK(m.held, 1'b1)
		`CHK(m.rd[0][31:0], e[31:0])
	endtask

	// Receiver stalls so the buffer fills and the burst must wait
	task automatic t_bwr;
		logic [63:0] d;
		logic [103:0] e;
		logic [103:0] r;
		d = D;
		q.delete();
		rq_en = 1'b0;
		fork
			m.run(1'b1, 1'b1, 4, 30'h2400, 4'h7, 4'h0, D);
			begin
				repeat (12) @(negedge clk);
				#5;
				`CHK(m.got < 4 && req_valid, 1'b1)
				`CHK(device_claim_n, 1'b0)
				rq_en = 1'b1;
			end
		join
		repeat (4) @(negedge clk);
		`CHK(m.bad || m.rdy_cyc < 2, 1'b0)
		for (int k = 0; k < 4; k++)
		begin
			e = {2'h3, k ? 8'hFF : 8'hF8, 30'h2400 + 30'(2 * k), d};
			r = q.pop_front();
			`CHK(r, e)
			d = d + 64'h0101_0101_0101_0101;
		end
		`CHK(req_valid, 1'b0)
		`CHK(device_claim_n, 1'b1)
	endtask

	task automatic t_brd;
		int b;
		b = num;
		m.run(1'b0, 1'b1, 4, 30'h2400, 4'h0, 4'h0, D);
		`CHK(m.bad || m.rdy_cyc < 3, 1'b0)
		for (int k = 0; k < 4; k++)
			`CHK(m.rd[k], pat(b + k))
		`CHK(upper_data_oe, 1'b0)
	endtask

	initial
	begin
		t_caps;
		t_wide_wr;
		t_wide_rd;
		t_narrow;
		t_bwr;
		t_brd;
		stop_test;
	end
endmodule
